// >>> testbench/sfe_dp_model.sv
// Purpose: datapath stand-in returning result conditions
// Assumes: one result per compute_go, dly+1 cycles after compute_go is sampled
// Notes: condition lines toggle while no result is valid
`timescale 1ns/1ps
module sfe_dp_model (
  input wire clk,
  input wire rst,
  input wire compute_go,
  input wire [3:0] compute_lanes,
  input wire [3:0] dly,
  input wire [11:0] cond,
  output reg post_valid,
  output reg [11:0] post_cond
);
  reg [3:0] cnt_reg;
  reg [3:0] lanes_reg;
  reg busy_reg;
  // ----
  // result phase
  // ----
  always @(posedge clk) begin
    post_valid <= 1'b0;
    post_cond <= ~post_cond;
    if (rst) begin
      busy_reg <= 1'b0;
      post_cond <= 12'h000;
    end else if (compute_go) begin
      busy_reg <= 1'b1;
      cnt_reg <= dly;
      lanes_reg <= compute_lanes;
    end else if (busy_reg && cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end else if (busy_reg) begin
      busy_reg <= 1'b0;
      post_valid <= 1'b1;
      post_cond <= cond & {3{lanes_reg}};
    end
  end
endmodule

// >>> testbench/sfe_exception_logic_sva.sv
// Purpose: port checks for the fp exception unit
// Assumes: one clock, synchronous reset
// Notes: attached by bind
`timescale 1ns/1ps
module sfe_chk (
  input logic clk,
  input logic rst,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_ack_o,
  input logic pre_valid,
  input logic pre_ready,
  input logic compute_go,
  input logic op_done,
  input logic simd_fp_fault,
  input logic undefined_opcode_fault,
  input logic [7:0] fault_vector,
  input logic fault_err_code_push
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // checks
  // ----
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  xf_vector_a: assert property (simd_fp_fault |-> fault_vector == 8'h13)
    else $error("bad fault vector");
  ud_vector_a: assert property (undefined_opcode_fault |-> fault_vector == 8'h00)
    else $error("bad undefined vector");
  no_err_code_a: assert property (!fault_err_code_push) else $error("error code pushed");
  one_outcome_a: assert property (
    $onehot0({compute_go, op_done, simd_fp_fault, undefined_opcode_fault}))
    else $error("two outcomes");
  pre_answer_a: assert property (pre_valid && pre_ready |=>
    compute_go || op_done || simd_fp_fault || undefined_opcode_fault) else $error("no answer");
  no_pending_a: assert property (
    op_done || simd_fp_fault || undefined_opcode_fault |-> pre_ready) else $error("left busy");
  xf_c: cover property (simd_fp_fault);
  ud_c: cover property (undefined_opcode_fault);
  post_c: cover property (compute_go ##[1:20] op_done);
endmodule
bind sfe_exception_logic sfe_chk i_chk (.*);

// >>> testbench/testbench.sv
// Purpose: self-checking bench for sfe_exception_logic
// Assumes: 250 MHz clock, datapath stand-in on the result side
// Notes: random ops from a fixed seed plus corner cases
`timescale 1ns/1ps
`include "sfe_regs.vh"
module testbench;
  logic clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, pre_valid = 0, os;
  logic [3:0] wb_sel_i = 4'hF, pre_nan_inv = '0, pre_qnan = '0, pre_inv = '0, pre_dz = '0;
  logic [3:0] pre_den = '0, dly = '0;
  logic [7:0] wb_adr_i = '0;
  logic [15:0] op_cs = '0;
  logic [31:0] wb_dat_i = '0, op_ip = '0, rd, exp_csr;
  logic [11:0] pq = '0;
  logic [5:0] m;
  wire [31:0] wb_dat_o, fault_ip;
  wire [15:0] fault_cs;
  wire [11:0] pc;
  wire [7:0] fault_vector;
  wire [3:0] post_ovf, post_unf, post_inx, compute_lanes, lane_default;
  wire wb_ack_o, pre_ready, post_valid, compute_go, op_done, simd_fp_fault;
  wire undefined_opcode_fault, fault_err_code_push;
  integer error_cnt = 0, n_checks = 0, cyc = 0, i, n_flt = 0;
  assign {post_ovf, post_unf, post_inx} = pc;
  sfe_exception_logic i_dut (.*);
  sfe_dp_model i_dp (.clk(clk), .rst(rst), .compute_go(compute_go),
    .compute_lanes(compute_lanes), .dly(dly), .cond(pq), .post_valid(post_valid), .post_cond(pc));
  always #2 clk = ~clk;
  // ----
  // expectation and bus tasks
  // ----
  function automatic [9:0] pre_f(input [19:0] c, input [5:0] mk);
    reg [5:0] f;
    reg [3:0] lv;
    f = '0;
    lv = '0;
    for (int k = 0; k < 4; k++) begin
      if (c[16+k]) f[0] = 1'b1;
      else if (!c[12+k]) begin
        f[0] |= c[8+k];
        f[1] |= c[4+k];
        if (c[k] && !(c[8+k] && !mk[0] || c[4+k] && !mk[1])) f[2] = 1'b1;
        lv[k] = !(c[8+k] || c[4+k]);
      end
    end
    return {f, lv};
  endfunction
  function automatic [5:0] post_f(input [11:0] p, input [3:0] lv, input [5:0] mk);
    reg [5:0] f;
    f = '0;
    for (int k = 0; k < 4; k++) if (lv[k]) begin
      f[3] |= p[8+k];
      f[4] |= p[4+k];
      if (!(p[8+k] && !mk[3] || p[4+k] && !mk[4])) f[5] |= p[k];
    end
    return f;
  endfunction
  task give_verdict;
    $display("errors=%0d checks=%0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input [47:0] got, input [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge clk);
      #1;
    end while (wb_ack_o !== 1'b1);
    @(posedge clk);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task run_op(input [19:0] c, input [11:0] p);
    reg [9:0] r;
    reg [5:0] f;
    reg [47:0] pt;
    reg [2:0] e3;
    reg [3:0] ld;
    r = pre_f(c, m);
    f = r[9:4];
    ld = ~r[3:0];
    pt = {16'($urandom), 32'($urandom)};
    @(posedge clk);
    {pre_valid, pre_nan_inv, pre_qnan, pre_inv, pre_dz, pre_den} <= {1'b1, c};
    {op_cs, op_ip, pq, dly} <= {pt, p, 4'($urandom)};
    @(posedge clk);
    pre_valid <= 1'b0;
    #1;
    if (!(|(f & ~m)) && r[3:0] != 4'h0) begin
      chk({compute_go, compute_lanes}, {1'b1, r[3:0]});
      f |= post_f(p, r[3:0], m);
      ld |= (p[11:8] | p[7:4]) & r[3:0];
      while ((op_done | simd_fp_fault | undefined_opcode_fault) !== 1'b1) begin
        @(posedge clk);
        #1;
      end
    end
    e3 = |(f & ~m) ? {os, !os, 1'b0} : 3'b001;
    chk({simd_fp_fault, undefined_opcode_fault, op_done}, e3);
    chk(lane_default, ld);
    if (|(f & ~m)) begin
      chk({fault_cs, fault_ip}, pt);
      n_flt++;
      wb(0, `SFE_ADR_FSTAT, 0);
      chk(rd, {16'h0, os ? `SFE_XF_VECTOR : 8'h00, 6'h0, !os, os});
      wb(1, `SFE_ADR_FSTAT, 32'h3);
      wb(0, `SFE_ADR_FSTAT, 0);
      chk(rd, {16'h0, os ? `SFE_XF_VECTOR : 8'h00, 8'h0});
    end
    exp_csr[5:0] |= f;
    wb(0, `SFE_ADR_CSR, 0);
    chk(rd, exp_csr);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict;
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(54));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wb(0, `SFE_ADR_CSR, 0);
    chk(rd, 32'h00000FC0);
    wb(1, 8'h20, 32'hFFFFFFFF);
    wb(0, 8'h20, 0);
    chk(rd, 0);
    wb(1, `SFE_ADR_CR4, 32'h00000001);
    {exp_csr, m, os} = {32'h00000FC0, 6'h3F, 1'b1};
    // qnan with divide, nan with denormal, lone denormal, invalid with denormal
    run_op(20'h2181E, 12'h505);
    for (i = 0; i < 60; i++) begin
      m = i[2] ? 6'h3F : 6'($urandom);
      os = 1'($urandom);
      wb(1, `SFE_ADR_CR4, {31'h0, os});
      exp_csr = {20'h0, m, i[0] ? exp_csr[5:0] : 6'h00};
      wb(1, `SFE_ADR_CSR, exp_csr);
      run_op(20'($urandom & $urandom & $urandom), 12'($urandom & $urandom));
    end
    {exp_csr, m} = {32'h00000FC0, 6'h3F};
    wb(1, `SFE_ADR_CSR, exp_csr);
    run_op(20'h0, 12'h00F);
    {exp_csr, m} = {32'h00000020, 6'h00};
    wb(1, `SFE_ADR_CSR, exp_csr);
    run_op(20'h0, 12'h000);
    wb(0, `SFE_ADR_FCNT, 0);
    chk(rd, n_flt);
    give_verdict;
  end
endmodule

// >>> verilog/sfe_exception_logic.v
// Purpose: flags, masks, lane priority and fault signalling for
//   packed floating-point numeric exceptions
// Assumes: datapath reports per-lane conditions in two phases
// Notes: registers reached over classic wishbone
//
// The Wishbone slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "sfe_regs.vh"

module sfe_exception_logic (
  input wire clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire pre_ready,
  input wire pre_valid,
  input wire [3:0] pre_nan_inv,
  input wire [3:0] pre_qnan,
  input wire [3:0] pre_inv,
  input wire [3:0] pre_dz,
  input wire [3:0] pre_den,
  input wire [15:0] op_cs,
  input wire [31:0] op_ip,
  input wire post_valid,
  input wire [3:0] post_ovf,
  input wire [3:0] post_unf,
  input wire [3:0] post_inx,
  output reg compute_go,
  output reg [3:0] compute_lanes,
  output reg op_done,
  output reg [3:0] lane_default,
  output reg simd_fp_fault,
  output reg undefined_opcode_fault,
  output reg [7:0] fault_vector,
  output reg [15:0] fault_cs,
  output reg [31:0] fault_ip,
  output wire fault_err_code_push
);

  // ------------------------------------------------------------
  // state and registers
  // ------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_POST = 1'b1;

  reg state_reg;
  reg state_next;
  reg [31:0] simd_fp_control_status_reg;
  reg [31:0] csr_next;
  reg [31:0] control_register_four;
  reg [1:0] fstat_reg;
  reg [15:0] fcnt_reg;
  reg [3:0] live_reg;
  reg [3:0] live_next;
  reg [15:0] cs_reg;
  reg [31:0] ip_reg;

  wire [5:0] mask_q;
  wire os_simd_fault_support_bit;

  assign mask_q = simd_fp_control_status_reg[`SFE_MASK_LSB +: 6];
  assign os_simd_fault_support_bit = control_register_four[`SFE_OS_BIT];

  // ------------------------------------------------------------
  // per-lane priority resolution
  // ------------------------------------------------------------
  wire [3:0] l1_v;
  wire [3:0] l2_v;
  wire [3:0] l3_v;
  wire [3:0] den_rep_v;
  wire [3:0] pre_flt_v;
  wire [3:0] pre_live_v;
  wire [3:0] pre_dflt_v;
  wire [3:0] set_i_v;
  wire [3:0] set_z_v;
  wire [3:0] ou_unm_v;
  wire [3:0] set_o_v;
  wire [3:0] set_u_v;
  wire [3:0] set_p_v;
  wire [3:0] post_flt_v;
  wire [3:0] post_dflt_v;

  // lanes are judged apart; only the fault, flag and compute_go decisions merge them
  genvar g;
  generate
    for (g = 0; g < `SFE_LANES; g = g + 1) begin : lane
      wire inv_unm;
      wire dz_unm;
      wire l3_unm;
      wire den_unm;
      wire inx_unm;
      assign l1_v[g] = pre_nan_inv[g];
      assign l2_v[g] = pre_qnan[g] & ~l1_v[g];
      assign l3_v[g] = (pre_inv[g] | pre_dz[g]) & ~l1_v[g] & ~l2_v[g];
      assign inv_unm = pre_inv[g] & ~mask_q[`SFE_C_INV];
      assign dz_unm = pre_dz[g] & ~mask_q[`SFE_C_DZ];
      assign l3_unm = inv_unm | dz_unm;
      // masked level three lets denormal through
      assign den_rep_v[g] = pre_den[g] & ~l1_v[g] & ~l2_v[g]
        & ~(l3_v[g] & l3_unm);
      assign den_unm = den_rep_v[g] & ~mask_q[`SFE_C_DEN];
      assign pre_flt_v[g] = (l1_v[g] & ~mask_q[`SFE_C_INV])
        | (l3_v[g] & l3_unm) | den_unm;
      assign set_i_v[g] = l1_v[g] | (l3_v[g] & pre_inv[g]);
      assign set_z_v[g] = l3_v[g] & pre_dz[g];
      // lanes with a default result need no arithmetic
      assign pre_dflt_v[g] = l1_v[g] | l2_v[g] | l3_v[g];
      assign pre_live_v[g] = ~pre_dflt_v[g];
      assign ou_unm_v[g] = live_reg[g]
        & ((post_ovf[g] & ~mask_q[`SFE_C_OVF])
        | (post_unf[g] & ~mask_q[`SFE_C_UNF]));
      assign set_o_v[g] = live_reg[g] & post_ovf[g];
      assign set_u_v[g] = live_reg[g] & post_unf[g];
      // masked level five lets inexact through
      assign set_p_v[g] = live_reg[g] & post_inx[g] & ~ou_unm_v[g];
      assign inx_unm = set_p_v[g] & ~mask_q[`SFE_C_INX];
      assign post_flt_v[g] = ou_unm_v[g] | inx_unm;
      assign post_dflt_v[g] = set_o_v[g] | set_u_v[g];
    end
  endgenerate

  // ------------------------------------------------------------
  // operation sequencing
  // ------------------------------------------------------------
  wire pre_take;
  wire post_take;
  wire pre_fault;
  wire post_fault;
  wire [5:0] pre_set;
  wire [5:0] post_set;

  // one operation in flight keeps every fault precise
  assign pre_ready = (state_reg == ST_IDLE);
  assign pre_take = pre_valid & pre_ready;
  assign post_take = post_valid & (state_reg == ST_POST);
  // fault depends on current conditions only
  assign pre_fault = |pre_flt_v;
  assign post_fault = |post_flt_v;
  assign pre_set = {3'b000, |den_rep_v, |set_z_v, |set_i_v};
  assign post_set = {|set_p_v, |set_u_v, |set_o_v, 3'b000};
  assign fault_err_code_push = 1'b0;

  always @* begin
    state_next = state_reg;
    live_next = live_reg;
    case (state_reg)
      ST_IDLE: begin
        // no post stage after a fault
        if (pre_take && !pre_fault && (|pre_live_v)) begin
          state_next = ST_POST;
          live_next = pre_live_v;
        end
      end
      ST_POST: begin
        if (post_take) begin
          state_next = ST_IDLE;
          live_next = 4'h0;
        end
      end
      default: begin
        state_next = ST_IDLE;
        live_next = 4'h0;
      end
    endcase
  end

  wire any_fault;
  wire op_end;

  assign any_fault = (pre_take & pre_fault) | (post_take & post_fault);
  assign op_end = (pre_take & (pre_fault | ~(|pre_live_v))) | post_take;

  always @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      live_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      live_reg <= live_next;
    end
  end

  // ------------------------------------------------------------
  // operation outcome
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      cs_reg <= 16'h0000;
      ip_reg <= 32'h00000000;
      compute_go <= 1'b0;
      compute_lanes <= 4'h0;
      op_done <= 1'b0;
      lane_default <= 4'h0;
      simd_fp_fault <= 1'b0;
      undefined_opcode_fault <= 1'b0;
    end else begin
      compute_go <= pre_take & ~pre_fault & (|pre_live_v);
      compute_lanes <= (pre_take & ~pre_fault) ? pre_live_v : 4'h0;
      op_done <= op_end & ~any_fault;
      // pointer kept for a fault found after computing
      if (pre_take) begin
        cs_reg <= op_cs;
        ip_reg <= op_ip;
        lane_default <= pre_dflt_v;
      end else if (post_take) begin
        lane_default <= lane_default | post_dflt_v;
      end
      // fault pulses on the faulting operation
      simd_fp_fault <= any_fault & os_simd_fault_support_bit;
      undefined_opcode_fault <= any_fault & ~os_simd_fault_support_bit;
    end
  end

  // ------------------------------------------------------------
  // fault record
  // ------------------------------------------------------------
  // held until the next fault so the handler can read it
  always @(posedge clk) begin
    if (rst) begin
      fault_vector <= 8'h00;
      fault_cs <= 16'h0000;
      fault_ip <= 32'h00000000;
    end else if (any_fault) begin
      // undefined opcode carries no vector of its own here
      fault_vector <= os_simd_fault_support_bit ? `SFE_XF_VECTOR : 8'h00;
      fault_cs <= pre_take ? op_cs : cs_reg;
      fault_ip <= pre_take ? op_ip : ip_reg;
    end
  end

  // ------------------------------------------------------------
  // wishbone slave
  // ------------------------------------------------------------
  wire req;
  wire wr_now;

  assign req = wb_cyc_i & wb_stb_i;
  // a write lands at the edge that shows ack to the master
  assign wr_now = req & wb_we_i & wb_ack_o;

  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] sel;
    integer i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  // ------------------------------------------------------------
  // flag update
  // ------------------------------------------------------------
  always @* begin
    csr_next = simd_fp_control_status_reg;
    if (wr_now && wb_adr_i == `SFE_ADR_CSR) begin
      csr_next = merge(simd_fp_control_status_reg, wb_dat_i, wb_sel_i)
        & `SFE_CSR_BITS;
    end
    // hardware only sets, set wins over clear
    if (pre_take) begin
      csr_next[5:0] = csr_next[5:0] | pre_set;
    end
    if (post_take) begin
      csr_next[5:0] = csr_next[5:0] | post_set;
    end
  end

  // ------------------------------------------------------------
  // read back
  // ------------------------------------------------------------
  reg [31:0] rd_mux;

  always @* begin
    case (wb_adr_i)
      `SFE_ADR_CSR: rd_mux = simd_fp_control_status_reg;
      `SFE_ADR_CR4: rd_mux = control_register_four;
      `SFE_ADR_FSTAT: rd_mux = {16'h0000, fault_vector, 6'h00, fstat_reg};
      `SFE_ADR_FCS: rd_mux = {16'h0000, fault_cs};
      `SFE_ADR_FIP: rd_mux = fault_ip;
      `SFE_ADR_FCNT: rd_mux = {16'h0000, fcnt_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ------------------------------------------------------------
  // status registers
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      simd_fp_control_status_reg <= `SFE_CSR_RST;
      control_register_four <= 32'h00000000;
      fstat_reg <= 2'b00;
      fcnt_reg <= 16'h0000;
    end else begin
      // one wait state: read data is registered at the edge that raises ack
      wb_ack_o <= req & ~wb_ack_o;
      if (req && !wb_ack_o) begin
        wb_dat_o <= rd_mux;
      end
      simd_fp_control_status_reg <= csr_next;
      // only the os support bit is kept
      if (wr_now && wb_adr_i == `SFE_ADR_CR4 && wb_sel_i[0]) begin
        control_register_four <= {{31{1'b0}}, wb_dat_i[`SFE_OS_BIT]};
      end
      // a new fault wins over a same-cycle clear
      if (any_fault) begin
        fstat_reg <= {~os_simd_fault_support_bit, os_simd_fault_support_bit};
      end else if (wr_now && wb_adr_i == `SFE_ADR_FSTAT && wb_sel_i[0]) begin
        fstat_reg <= fstat_reg & ~wb_dat_i[1:0];
      end
      if (any_fault) begin
        fcnt_reg <= fcnt_reg + 16'h0001;
      end
    end
  end

endmodule

// >>> verilog/sfe_regs.vh
// Purpose: constants for the packed floating-point exception unit
// Assumes: classic wishbone slave, byte addresses, 32-bit data
// Notes: definitions only
//
// Behaviour
// - six conditions, each with its own flag bit and mask bit
// - invalid, divide-by-zero and denormal judged from operands before computing
// - overflow, underflow and inexact judged only after the result exists
// - masked condition sets flag, execution continues; all but denormal and inexact give a default result
// - unmasked condition with os support bit set raises fault vector 19
// - unmasked condition with os support bit clear raises undefined opcode
// - faults are precise and immediate, nothing left pending
// - clearing a mask over an already set flag raises nothing
// - flags set for each condition that the lane priority lets flag in any lane
// - one condition per lane, by fixed priority, highest reported
// - quiet NaN operand outranks lower conditions without flagging them
// - masked levels three to five still let lower conditions flag
// - fault keeps faulting instruction pointer and pushes no error code
`ifndef SFE_REGS_VH
`define SFE_REGS_VH

`define SFE_LANES 4
`define SFE_ADR_CSR 8'h00
`define SFE_ADR_CR4 8'h04
`define SFE_ADR_FSTAT 8'h08
`define SFE_ADR_FCS 8'h0C
`define SFE_ADR_FIP 8'h10
`define SFE_ADR_FCNT 8'h14

`define SFE_C_INV 0
`define SFE_C_DZ 1
`define SFE_C_DEN 2
`define SFE_C_OVF 3
`define SFE_C_UNF 4
`define SFE_C_INX 5
`define SFE_MASK_LSB 6
`define SFE_CSR_RST 32'h00000FC0
`define SFE_CSR_BITS 32'h00000FFF
`define SFE_OS_BIT 0
`define SFE_XF_VECTOR 8'h13

`endif
